/* nsx_params.svh */
// constants for the nibble swap, xor and direction-load execute block
`ifndef NSX_PARAMS_SVH
`define NSX_PARAMS_SVH

// instruction and data widths
`define NSX_INSTR_W        12
`define NSX_DATA_W         8
`define NSX_FADDR_W        5

// opcode match patterns, value under mask
`define NSX_SWAP_MASK      12'hFC0
`define NSX_SWAP_VAL       12'h380
`define NSX_XORF_MASK      12'hFC0
`define NSX_XORF_VAL       12'h180
`define NSX_XORL_MASK      12'hF00
`define NSX_XORL_VAL       12'hF00
`define NSX_DIR_MASK       12'hFF8
`define NSX_DIR_VAL        12'h000

// field positions inside the opcode
`define NSX_DEST_BIT       5
`define NSX_FADDR_HI       4
`define NSX_LIT_HI         7
`define NSX_DIRSEL_HI      2

// direction-load selector range
`define NSX_DIRSEL_FIRST   3'h5
`define NSX_DIRSEL_LAST    3'h7
`define NSX_DIR_COUNT      3

// reset values: all port pins start as inputs
`define NSX_DIR_RESET      8'hFF
`define NSX_W_RESET        8'h00

`endif

/* nsx_pkg.sv */
// types shared by the nibble swap, xor and direction-load execute block
`default_nettype none
`include "nsx_params.svh"

package nsx_pkg;

  typedef enum logic [2:0] {
    NSX_OP_NONE = 3'b000,
    NSX_OP_SWAP = 3'b001,
    NSX_OP_DIR  = 3'b010,
    NSX_OP_XORL = 3'b011,
    NSX_OP_XORF = 3'b100
  } nsx_op_e;

  typedef struct packed {
    nsx_op_e                     op;
    logic                        dest_f;
    logic [`NSX_FADDR_W-1:0]     faddr;
    logic [`NSX_DATA_W-1:0]      literal;
    logic [2:0]                  dir_sel;
  } nsx_decode_s;

  typedef struct packed {
    logic                        we;
    logic [`NSX_FADDR_W-1:0]     addr;
    logic [`NSX_DATA_W-1:0]      data;
  } nsx_file_wr_s;

  typedef struct packed {
    logic [`NSX_DATA_W-1:0]      w;
    logic                        zero;
    logic [`NSX_DIR_COUNT-1:0][`NSX_DATA_W-1:0] dir;
    nsx_file_wr_s                file_wr;
    logic                        done;
    logic                        unknown;
    logic                        bad_dir;
  } nsx_state_s;

endpackage : nsx_pkg
`default_nettype wire

/* nsx_decode.sv */
// opcode decoder for the nibble swap, xor and direction-load execute block
`timescale 1ns/1ps
`default_nettype none
`include "nsx_params.svh"

module nsx_decode (
  // instruction word
  input  wire logic [`NSX_INSTR_W-1:0] instr_word,
  // decoded fields
  output var  nsx_pkg::nsx_decode_s    dec
);
  import nsx_pkg::*;

  always_comb begin
    dec         = '0;
    dec.op      = NSX_OP_NONE;
    dec.dest_f  = instr_word[`NSX_DEST_BIT];
    dec.faddr   = instr_word[`NSX_FADDR_HI:0];
    dec.literal = instr_word[`NSX_LIT_HI:0];
    dec.dir_sel = instr_word[`NSX_DIRSEL_HI:0];
    if ((instr_word & `NSX_SWAP_MASK) == `NSX_SWAP_VAL) begin
      dec.op = NSX_OP_SWAP; // RULE_01
    end else if ((instr_word & `NSX_XORF_MASK) == `NSX_XORF_VAL) begin
      dec.op = NSX_OP_XORF; // RULE_06
    end else if ((instr_word & `NSX_XORL_MASK) == `NSX_XORL_VAL) begin
      dec.op = NSX_OP_XORL; // RULE_05
    end else if ((instr_word & `NSX_DIR_MASK) == `NSX_DIR_VAL) begin
      dec.op = NSX_OP_DIR; // RULE_03
    end
  end

endmodule : nsx_decode
`default_nettype wire

/* nsx_exec.sv */
// execute unit for nibble swap, register/literal xor and direction load
`timescale 1ns/1ps
`default_nettype none
`include "nsx_params.svh"

// Summary of operation
// RULE_01 - A nibble exchange opcode reads the addressed file register, swaps its two nibbles and leaves every flag alone.
// RULE_02 - The swapped byte goes to the accumulator when the destination bit is 0 and back to the file register when it is 1.
// RULE_03 - A direction-load opcode copies the accumulator into the direction register picked by the low three opcode bits, flags untouched.
// RULE_04 - Software only uses selector values 5, 6 or 7 for a direction load; other values are undefined.
// RULE_05 - A literal xor opcode xors the accumulator with the low eight opcode bits, writes the accumulator and updates zero.
// RULE_06 - A register xor opcode xors the accumulator with the file register at the five-bit address and updates zero.
// RULE_07 - The register xor result goes to the accumulator when the destination bit is 0 and to the file register when it is 1.
// RULE_08 - Each instruction is one word executed in one cycle, and zero is set exactly when an xor result is zero.
module nsx_exec #(
  parameter int DATA_W  = `NSX_DATA_W,
  parameter int FADDR_W = `NSX_FADDR_W
) (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  // instruction issue from the fetch stage
  input  wire logic                    instr_valid,
  input  wire logic [`NSX_INSTR_W-1:0] instr_word,
  // register file read side
  output logic [`NSX_FADDR_W-1:0]      file_raddr,
  input  wire logic [`NSX_DATA_W-1:0]  file_rdata,
  // register file write side
  output var  nsx_pkg::nsx_file_wr_s   file_wr,
  // accumulator load from the rest of the core
  input  wire logic                    w_load_en,
  input  wire logic [`NSX_DATA_W-1:0]  w_load_data,
  // accumulator and zero flag
  output logic [`NSX_DATA_W-1:0]       w_value,
  output logic                         zero_flag,
  // port direction latches, selectors 5, 6 and 7
  output logic [`NSX_DATA_W-1:0]       port_a_direction,
  output logic [`NSX_DATA_W-1:0]       port_b_direction,
  output logic [`NSX_DATA_W-1:0]       port_c_direction,
  // per-instruction status pulses
  output logic                         instr_done,
  output logic                         instr_unknown,
  output logic                         dir_sel_invalid
);
  import nsx_pkg::*;

  // the datapath is built around byte nibbles and a 32-entry file
  if (DATA_W != `NSX_DATA_W || FADDR_W != `NSX_FADDR_W) begin : g_chk
    $error("nsx_exec supports only 8-bit data and 5-bit file addresses");
  end

  nsx_decode_s             dec;
  nsx_state_s              st_r;
  nsx_state_s              st_nxt;
  logic [`NSX_DATA_W-1:0]  src_byte;
  logic [`NSX_DATA_W-1:0]  swap_byte;
  logic [`NSX_DATA_W-1:0]  xor_byte;
  logic [1:0]              dir_idx;
  logic                    dir_ok;

  nsx_decode u_decode (
    .instr_word (instr_word),
    .dec        (dec)
  );

  // file operand address straight from the opcode field
  assign file_raddr = dec.faddr;

  // the file write lands one edge late, so a following instruction on the
  // same address would see the old byte; forward the pending write instead
  always_comb begin
    if (st_r.file_wr.we && st_r.file_wr.addr == dec.faddr) begin
      src_byte = st_r.file_wr.data;
    end else begin
      src_byte = file_rdata;
    end
  end

  assign swap_byte = {src_byte[3:0], src_byte[7:4]}; // RULE_01
  assign xor_byte  = st_r.w ^ ((dec.op == NSX_OP_XORL) ?
                               dec.literal : src_byte); // RULE_05 RULE_06

  // selectors below 5 are undefined for software; they are dropped here
  assign dir_ok  = dec.dir_sel >= `NSX_DIRSEL_FIRST; // RULE_04
  assign dir_idx = 2'(dec.dir_sel - `NSX_DIRSEL_FIRST);

  always_comb begin
    st_nxt            = st_r;
    st_nxt.file_wr.we = 1'b0;
    st_nxt.done       = 1'b0;
    st_nxt.unknown    = 1'b0;
    st_nxt.bad_dir    = 1'b0;
    // core load first, so an instruction of this unit in the same cycle wins
    if (w_load_en) begin
      st_nxt.w = w_load_data;
    end
    if (instr_valid) begin
      // every accepted opcode retires at the next edge
      st_nxt.done = dec.op != NSX_OP_NONE; // RULE_08
      case (dec.op)
        NSX_OP_SWAP: begin
          // no flag is written on this path
          if (dec.dest_f) begin
            st_nxt.file_wr.we   = 1'b1; // RULE_02
            st_nxt.file_wr.addr = dec.faddr;
            st_nxt.file_wr.data = swap_byte;
          end else begin
            st_nxt.w = swap_byte; // RULE_02
          end
        end
        NSX_OP_DIR: begin
          if (dir_ok) begin
            st_nxt.dir[dir_idx] = st_r.w; // RULE_03
          end else begin
            st_nxt.bad_dir = 1'b1; // RULE_04
          end
        end
        NSX_OP_XORL: begin
          st_nxt.w    = xor_byte; // RULE_05
          st_nxt.zero = xor_byte == '0; // RULE_08
        end
        NSX_OP_XORF: begin
          st_nxt.zero = xor_byte == '0; // RULE_06 RULE_08
          if (dec.dest_f) begin
            st_nxt.file_wr.we   = 1'b1; // RULE_07
            st_nxt.file_wr.addr = dec.faddr;
            st_nxt.file_wr.data = xor_byte;
          end else begin
            st_nxt.w = xor_byte; // RULE_07
          end
        end
        default: begin
          // opcodes of other units: left for them, reported only
          st_nxt.unknown = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r         <= '0;
      st_r.w       <= `NSX_W_RESET;
      st_r.dir[0]  <= `NSX_DIR_RESET;
      st_r.dir[1]  <= `NSX_DIR_RESET;
      st_r.dir[2]  <= `NSX_DIR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign file_wr          = st_r.file_wr;
  assign w_value          = st_r.w;
  assign zero_flag        = st_r.zero;
  assign port_a_direction = st_r.dir[0];
  assign port_b_direction = st_r.dir[1];
  assign port_c_direction = st_r.dir[2];
  assign instr_done       = st_r.done;
  assign instr_unknown    = st_r.unknown;
  assign dir_sel_invalid  = st_r.bad_dir;

endmodule : nsx_exec
`default_nettype wire

/* nsx_exec_monitor.sv */
// assertion checker on the execute block ports
`timescale 1ns/1ps
`default_nettype none
module nsx_exec_monitor (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // instruction and operand
  input wire logic        instr_valid,
  input wire logic [11:0] instr_word,
  input wire logic [7:0]  file_rdata,
  // results
  input wire nsx_pkg::nsx_file_wr_s file_wr,
  input wire logic [7:0]  w_value,
  input wire logic        zero_flag,
  input wire logic [7:0]  port_b_direction,
  input wire logic        instr_done
);
  import nsx_pkg::*;
  logic sw, xf, xl, dr, fw;
  logic [7:0] swp, xfv, xlv;
  assign sw = instr_valid && instr_word[11:6] == 6'h0E;
  assign xf = instr_valid && instr_word[11:6] == 6'h06;
  assign xl = instr_valid && instr_word[11:8] == 4'hF;
  assign dr = instr_valid && instr_word[11:3] == 9'h000;
  // a forwarded operand is not on file_rdata, so skip those cycles
  assign fw = file_wr.we && file_wr.addr == instr_word[4:0];
  assign swp = {file_rdata[3:0], file_rdata[7:4]};
  assign xfv = w_value ^ file_rdata;
  assign xlv = w_value ^ instr_word[7:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_swap_to_w: assert property (
    sw && !instr_word[5] && !fw |=> w_value == $past(swp))
    else $error("swap result to w wrong");
  a_swap_to_file: assert property (
    sw && instr_word[5] && !fw |=> file_wr.we && file_wr.data == $past(swp))
    else $error("swap result to file wrong");
  a_swap_keeps_zero: assert property (sw |=> $stable(zero_flag))
    else $error("swap touched zero");
  a_dir_load_b: assert property (
    dr && instr_word[2:0] == 3'h6 |=> port_b_direction == $past(w_value))
    else $error("direction load wrong");
  a_dir_keeps_zero: assert property (dr |=> $stable(zero_flag))
    else $error("direction load touched zero");
  a_xorl_result: assert property (
    xl |=> w_value == $past(xlv) && zero_flag == (w_value == 8'h00))
    else $error("literal xor wrong");
  a_xorf_to_w: assert property (
    xf && !instr_word[5] && !fw |=> w_value == $past(xfv))
    else $error("register xor to w wrong");
  a_xorf_to_file: assert property (
    xf && instr_word[5] && !fw |=> file_wr.we && file_wr.data == $past(xfv)
    && zero_flag == (file_wr.data == 8'h00))
    else $error("register xor to file wrong");
  a_one_cycle: assert property (sw || xf || xl || dr |=> instr_done)
    else $error("instruction not retired in one cycle");
  c_swap: cover property (sw ##1 file_wr.we);
  c_zero: cover property (xf ##1 zero_flag);
  c_dir: cover property (dr ##1 instr_done);
endmodule : nsx_exec_monitor
`default_nettype wire

/* test_nsx_exec.sv */
// self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: %h %h", $time, a, e); end end
module test_nsx_exec;
  import nsx_pkg::*;
  logic clk_sys, reset_n, instr_valid, w_load_en, zero_flag;
  logic instr_done, instr_unknown, dir_sel_invalid;
  logic [11:0] instr_word;
  logic [7:0] file_rdata, w_load_data, w_value, pa, pb, pc;
  logic [7:0] rf [32];
  logic [4:0] file_raddr;
  nsx_file_wr_s file_wr;
  int error_cnt = 0;
  int check_count = 0;
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  nsx_exec u_nsx_exec (.clk_sys, .reset_n, .instr_valid, .instr_word,
    .file_raddr, .file_rdata, .file_wr, .w_load_en, .w_load_data,
    .w_value, .zero_flag, .port_a_direction(pa), .port_b_direction(pb),
    .port_c_direction(pc), .instr_done, .instr_unknown, .dir_sel_invalid);
  // file model commits on the edge that ends the write pulse
  assign file_rdata = rf[file_raddr];
  always @(posedge clk_sys) if (file_wr.we) rf[file_wr.addr] <= file_wr.data;
  task op(input logic [11:0] w);
    @(posedge clk_sys);
    instr_valid <= 1'h1;
    instr_word <= w;
    @(posedge clk_sys);
    instr_valid <= 1'h0;
    #1;
  endtask : op
  task setw(input logic [7:0] v);
    @(posedge clk_sys);
    w_load_en <= 1'h1;
    w_load_data <= v;
    @(posedge clk_sys);
    w_load_en <= 1'h0;
  endtask : setw
  task t_swap;
    rf[3] = 8'hA5;
    op(12'h383);
    `CHK({w_value, instr_done}, {8'h5A, 1'h1})
    `CHK(file_raddr, 5'h03)
    op(12'h3A3);
    `CHK({file_wr, w_value}, {1'h1, 5'h03, 8'h5A, 8'h5A})
    $display("test swap done");
  endtask : t_swap
  task t_xorl;
    setw(8'hB5);
    op(12'hFAF);
    `CHK({w_value, zero_flag}, {8'h1A, 1'h0})
    op(12'hF1A);
    `CHK({w_value, zero_flag}, {8'h00, 1'h1})
    op(12'h383);
    `CHK({w_value, zero_flag}, {8'hA5, 1'h1})
    $display("test xorl done");
  endtask : t_xorl
  task t_dir;
    for (int s = 5; s < 8; s++) begin
      setw(8'hA0 + 8'(s));
      op(12'(s));
    end
    `CHK({pa, pb, pc, zero_flag}, {24'hA5A6A7, 1'h1})
    op(12'h003);
    `CHK({pa, pb, pc, dir_sel_invalid}, {24'hA5A6A7, 1'h1})
    op(12'h0FF);
    `CHK({instr_unknown, instr_done}, 2'h2)
    $display("test dir done");
  endtask : t_dir
  task t_xorf;
    rf[2] = 8'hB5;
    setw(8'hB5);
    op(12'h182);
    `CHK({w_value, zero_flag}, {8'h00, 1'h1})
    setw(8'h0F);
    op(12'h1A2);
    `CHK({file_wr, w_value}, {1'h1, 5'h02, 8'hBA, 8'h0F})
    // back to back on one address exercises operand forwarding
    @(posedge clk_sys);
    instr_valid <= 1'h1;
    instr_word <= 12'h3A2;
    @(posedge clk_sys);
    instr_word <= 12'h182;
    @(posedge clk_sys);
    instr_valid <= 1'h0;
    #1;
    `CHK({w_value, zero_flag}, {8'hA4, 1'h0})
    $display("test xorf done");
  endtask : t_xorf
  task final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  initial begin
    reset_n = 1'h0;
    instr_valid = 1'h0;
    instr_word = 12'h000;
    w_load_en = 1'h0;
    w_load_data = 8'h00;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'h1;
    t_swap;
    t_xorl;
    t_dir;
    t_xorf;
    final_report;
  end
  // tests need well under a hundred cycles
  initial begin
    #40000;
    error_cnt++;
    final_report;
  end
endmodule : test_nsx_exec
bind nsx_exec nsx_exec_monitor u_nsx_exec_monitor (.clk_sys, .reset_n,
  .instr_valid, .instr_word, .file_rdata, .file_wr, .w_value, .zero_flag,
  .port_b_direction, .instr_done);
`default_nettype wire
